/* File: src/ssr_regs.vh */
`ifndef SSR_REGS_VH
`define SSR_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SSR_OFF_CTRL      8'h00
`define SSR_OFF_DIV       8'h04
`define SSR_OFF_CLKM      8'h10
`define SSR_OFF_FRMM      8'h14
`define SSR_OFF_HOLD      8'h20
`define SSR_OFF_SYNC      8'h30
`define SSR_OFF_CMP0      8'h38
`define SSR_OFF_CMP1      8'h3C
`define SSR_OFF_STAT      8'h40

// ----------------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------------
`define SSR_RST_CLKM      32'h00000000
`define SSR_RST_FRMM      32'h00000000
`define SSR_MASK_CLKM     32'hFFFF1FFF
`define SSR_MASK_FRMM     32'hF17F0FBF

// ----------------------------------------------------------------------
// Control register bits
// ----------------------------------------------------------------------
`define SSR_CTRL_EN       0
`define SSR_CTRL_DIS      1

// ----------------------------------------------------------------------
// Receive clock mode fields (lowest bit of each)
// ----------------------------------------------------------------------
`define SSR_RC_SRC        0
`define SSR_RC_DRV        2
`define SSR_RC_INV        5
`define SSR_RC_GATE       6
`define SSR_RC_START      8
`define SSR_RC_STOP       12
`define SSR_RC_DLY        16
`define SSR_RC_PER        24

// ----------------------------------------------------------------------
// Receive frame mode fields (lowest bit of each)
// ----------------------------------------------------------------------
`define SSR_RF_WLEN       0
`define SSR_RF_LOOP       5
`define SSR_RF_ORDER      7
`define SSR_RF_WORDS      8
`define SSR_RF_SLEN_LO    16
`define SSR_RF_SHAPE      20
`define SSR_RF_EDGE       24
`define SSR_RF_SLEN_HI    28

// ----------------------------------------------------------------------
// Status register bits
// ----------------------------------------------------------------------
`define SSR_ST_READY      0
`define SSR_ST_OVR        1
`define SSR_ST_SYNC       2
`define SSR_ST_EN         3
`define SSR_ST_BUSY       4

`endif

/* File: src/ssr_rx_clock_frame.v */
// Notes on behaviour
// - Start 0 runs continuously once enabled; 1 follows transmitter start.
// - Starts 2-7 follow frame sync level or edge; 8 waits for compare-0.
// - Gating: continuous, only while sync low, or only while sync high.
// - Invert set: sample on rising clock edge, launch sync on falling edge.
// - Invert clear: sample on falling clock edge, launch sync on rising edge.
// - Inversion never changes the clock level driven on the pin.
// - Clock pin drive mode: input only, always driven, or driven while busy.
// - Clock source: divided clock, transmit clock, or receive clock pin.
// - Sync-seen flag sets on rising sync edge, or falling when selected.
// - Sync output shape: none, pulses, level during transfer, or toggle.
// - Sync length sets generated sync length and captured sync bit count.
// - Sync length also sets compared bit count in compare start mode.
// - Generated sync pulse lasts length plus one receive clock periods.
// - Sync length is high part above low part as a byte.
// - Each transfer start receives words-per-frame plus one words.
// - Bit order flag set puts first bit in MSB, else in LSB.
// - Loop mode takes data, sync and clock from the transmitter.
// - Nonzero start delay inserts that many receive cycles before start.
// - Stop bit keeps compare-started reception running until compare-1.
// - Each word holds word bit count plus one bits.
// - Nonzero period makes a sync every two times period plus two periods.
`timescale 1ns/1ns
`include "ssr_regs.vh"

module ssr_rx_clock_frame (
  input  wire        MCLK_I,
  input  wire        SYS_RST_I,
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  input  wire        RX_DATA_I,
  input  wire        RX_FS_I,
  output reg         RX_FS_O,
  output reg         RX_FS_OE_N_O,
  input  wire        RX_CLK_I,
  output reg         RX_CLK_O,
  output reg         RX_CLK_OE_N_O,
  input  wire        TX_DATA_I,
  input  wire        TX_FS_I,
  input  wire        TX_CLK_I,
  input  wire        TX_START_I
);

  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WAIT  = 3'h1;
  localparam [2:0] ST_DELAY = 3'h2;
  localparam [2:0] ST_SYNC  = 3'h3;
  localparam [2:0] ST_DATA  = 3'h4;

  // --------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------
  reg  [5:0]  pin_s1_q;
  reg  [5:0]  pin_s2_q;

  always @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      pin_s1_q <= 6'h00;
      pin_s2_q <= 6'h00;
    end else begin
      pin_s1_q <= {TX_CLK_I, TX_FS_I, TX_DATA_I, RX_CLK_I, RX_FS_I, RX_DATA_I};
      pin_s2_q <= pin_s1_q;
    end
  end

  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  reg  [31:0] receive_clock_mode_q;
  reg  [31:0] receive_frame_mode_q;
  reg  [11:0] div_q;
  reg  [15:0] cmp0_q;
  reg  [15:0] cmp1_q;
  reg         en_q;
  reg  [31:0] hold_q;
  reg  [31:0] sync_hold_q;
  reg         ready_q;
  reg         ovr_q;
  reg         sync_seen_q;
  reg  [2:0]  state_q;

  wire        req     = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire        wr      = req & WB_WE_I;
  wire        rd      = req & ~WB_WE_I;
  wire [31:0] wmask   = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                         {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  wire [7:0]  widx    = {2'h0, WB_ADR_I[7:2]};
  wire        wr_ctrl = wr & (widx == `SSR_OFF_CTRL >> 2);
  wire        rd_hold = rd & (widx == `SSR_OFF_HOLD >> 2);
  wire        rd_stat = rd & (widx == `SSR_OFF_STAT >> 2);
  wire        busy    = (state_q == ST_SYNC) | (state_q == ST_DATA);

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [31:0] bm;
    begin
      merge = (old & ~bm) | (nw & bm);
    end
  endfunction

  always @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      receive_clock_mode_q <= `SSR_RST_CLKM;
      receive_frame_mode_q <= `SSR_RST_FRMM;
      div_q  <= 12'h000;
      cmp0_q <= 16'h0000;
      cmp1_q <= 16'h0000;
    end else if (wr) begin
      case (widx)
        `SSR_OFF_DIV >> 2: begin
          div_q <= (WB_DAT_I[11:0] & wmask[11:0]) | (div_q & ~wmask[11:0]);
        end
        `SSR_OFF_CLKM >> 2: begin
          receive_clock_mode_q <= merge(receive_clock_mode_q, WB_DAT_I,
                                        wmask & `SSR_MASK_CLKM);
        end
        `SSR_OFF_FRMM >> 2: begin
          receive_frame_mode_q <= merge(receive_frame_mode_q, WB_DAT_I,
                                        wmask & `SSR_MASK_FRMM);
        end
        `SSR_OFF_CMP0 >> 2: begin
          cmp0_q <= (WB_DAT_I[15:0] & wmask[15:0]) | (cmp0_q & ~wmask[15:0]);
        end
        `SSR_OFF_CMP1 >> 2: begin
          cmp1_q <= (WB_DAT_I[15:0] & wmask[15:0]) | (cmp1_q & ~wmask[15:0]);
        end
        default: begin
          receive_clock_mode_q <= receive_clock_mode_q;
        end
      endcase
    end
  end

  // Reads are captured at the request edge, so a read that clears a flag
  // still returns the value it had before the clear.
  always @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= req;
      if (rd) begin
        case (widx)
          `SSR_OFF_DIV >> 2:  WB_DAT_O <= {20'h00000, div_q};
          `SSR_OFF_CLKM >> 2: WB_DAT_O <= receive_clock_mode_q;
          `SSR_OFF_FRMM >> 2: WB_DAT_O <= receive_frame_mode_q;
          `SSR_OFF_HOLD >> 2: WB_DAT_O <= hold_q;
          `SSR_OFF_SYNC >> 2: WB_DAT_O <= sync_hold_q;
          `SSR_OFF_CMP0 >> 2: WB_DAT_O <= {16'h0000, cmp0_q};
          `SSR_OFF_CMP1 >> 2: WB_DAT_O <= {16'h0000, cmp1_q};
          `SSR_OFF_STAT >> 2: WB_DAT_O <= {27'h0000000, busy, en_q,
                                           sync_seen_q, ovr_q, ready_q};
          default:            WB_DAT_O <= 32'h00000000;
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Field decode
  // --------------------------------------------------------------------
  wire [1:0]  f_src   = receive_clock_mode_q[`SSR_RC_SRC+1:`SSR_RC_SRC];
  wire [2:0]  f_drv   = receive_clock_mode_q[`SSR_RC_DRV+2:`SSR_RC_DRV];
  wire        f_inv   = receive_clock_mode_q[`SSR_RC_INV];
  wire [1:0]  f_gate  = receive_clock_mode_q[`SSR_RC_GATE+1:`SSR_RC_GATE];
  wire [3:0]  f_start = receive_clock_mode_q[`SSR_RC_START+3:`SSR_RC_START];
  wire        f_stop  = receive_clock_mode_q[`SSR_RC_STOP];
  wire [7:0]  f_dly   = receive_clock_mode_q[`SSR_RC_DLY+7:`SSR_RC_DLY];
  wire [7:0]  f_per   = receive_clock_mode_q[`SSR_RC_PER+7:`SSR_RC_PER];
  wire [4:0]  f_wlen  = receive_frame_mode_q[`SSR_RF_WLEN+4:`SSR_RF_WLEN];
  wire        f_loop  = receive_frame_mode_q[`SSR_RF_LOOP];
  wire        f_order = receive_frame_mode_q[`SSR_RF_ORDER];
  wire [3:0]  f_words = receive_frame_mode_q[`SSR_RF_WORDS+3:`SSR_RF_WORDS];
  wire [2:0]  f_shape = receive_frame_mode_q[`SSR_RF_SHAPE+2:`SSR_RF_SHAPE];
  wire        f_edge  = receive_frame_mode_q[`SSR_RF_EDGE];
  wire [7:0]  f_slen  = {
                receive_frame_mode_q[`SSR_RF_SLEN_HI+3:`SSR_RF_SLEN_HI],
                receive_frame_mode_q[`SSR_RF_SLEN_LO+3:`SSR_RF_SLEN_LO]};

  // --------------------------------------------------------------------
  // Receive clock selection and edges
  // --------------------------------------------------------------------
  reg  [11:0] div_cnt_q;
  reg         div_clk_q;
  reg         clk_prev_q;
  reg         fs_out_q;

  always @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      div_cnt_q <= 12'h000;
      div_clk_q <= 1'b0;
    end else if (div_q == 12'h000) begin
      div_cnt_q <= 12'h000;
      div_clk_q <= 1'b0;
    end else if (div_cnt_q == div_q - 12'h001) begin
      div_cnt_q <= 12'h000;
      div_clk_q <= ~div_clk_q;
    end else begin
      div_cnt_q <= div_cnt_q + 12'h001;
    end
  end

  wire        fs_drive = (f_shape != 3'h0);
  wire        data_in  = f_loop ? pin_s2_q[3] : pin_s2_q[0];
  wire        fs_in    = f_loop ? pin_s2_q[4] :
                         (fs_drive ? fs_out_q : pin_s2_q[1]);
  wire        sel_clk  = f_loop ? pin_s2_q[5] :
                         (f_src == 2'h0) ? div_clk_q :
                         (f_src == 2'h1) ? pin_s2_q[5] :
                         (f_src == 2'h2) ? pin_s2_q[2] : 1'b0;
  wire        c_rise   = sel_clk & ~clk_prev_q;
  wire        c_fall   = ~sel_clk & clk_prev_q;
  wire        gate_ok  = (f_gate == 2'h0) | ((f_gate == 2'h1) & ~fs_in) |
                         ((f_gate == 2'h2) & fs_in);
  wire        tick_s   = gate_ok & (f_inv ? c_rise : c_fall);
  wire        tick_l   = gate_ok & (f_inv ? c_fall : c_rise);

  always @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      clk_prev_q    <= 1'b0;
      RX_CLK_O      <= 1'b0;
      RX_CLK_OE_N_O <= 1'b1;
    end else begin
      clk_prev_q    <= sel_clk;
      RX_CLK_O      <= sel_clk;
      RX_CLK_OE_N_O <= ~((f_drv == 3'h1) | ((f_drv == 3'h2) & busy));
    end
  end

  // --------------------------------------------------------------------
  // Start detection and compare windows
  // --------------------------------------------------------------------
  reg         fs_prev_q;
  reg         tx_pend_q;
  reg         cont_q;
  reg  [15:0] cmp_sh_q;

  wire [15:0] win_nxt = {cmp_sh_q[14:0], data_in};
  wire [15:0] cmask   = (f_slen >= 8'h0F) ? 16'hFFFF :
                        ((16'h0001 << f_slen[3:0]) << 1) - 16'h0001;
  wire        match0  = ((win_nxt ^ cmp0_q) & cmask) == 16'h0000;
  wire        match1  = ((win_nxt ^ cmp1_q) & cmask) == 16'h0000;
  wire        fs_rise = fs_in & ~fs_prev_q;
  wire        fs_fall = ~fs_in & fs_prev_q;
  wire        fs_mode = (f_start >= 4'h2) & (f_start <= 4'h7);
  reg         start_ev;

  always @* begin
    start_ev = 1'b0;
    case (f_start)
      4'h0: start_ev = 1'b1;
      4'h1: start_ev = tx_pend_q;
      4'h2: start_ev = ~fs_in;
      4'h3: start_ev = fs_in;
      4'h4: start_ev = fs_fall;
      4'h5: start_ev = fs_rise;
      4'h6: start_ev = fs_rise | fs_fall;
      4'h7: start_ev = fs_rise | fs_fall;
      4'h8: start_ev = match0;
      default: start_ev = 1'b0;
    endcase
  end

  always @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      fs_prev_q <= 1'b0;
      cmp_sh_q  <= 16'h0000;
    end else if (tick_s) begin
      fs_prev_q <= fs_in;
      cmp_sh_q  <= win_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Receive sequencer
  // --------------------------------------------------------------------
  reg  [7:0]  dly_cnt_q;
  reg  [7:0]  bit_cnt_q;
  reg  [3:0]  word_cnt_q;
  reg  [31:0] word_sh_q;
  reg         xfer_go;
  reg         word_done;

  wire [2:0]  go_state  = (f_dly != 8'h00) ? ST_DELAY :
                          (fs_mode ? ST_SYNC : ST_DATA);
  wire [31:0] word_base = (bit_cnt_q == 8'h00) ? 32'h00000000 : word_sh_q;
  wire [31:0] word_nxt  = f_order ? {word_base[30:0], data_in} :
                          (word_base | ({31'h00000000, data_in}
                                        << bit_cnt_q[4:0]));
  // A new capture starts clean, so bits of an earlier frame never leak in.
  wire [31:0] sync_base = (bit_cnt_q == 8'h00) ? 32'h00000000 : sync_hold_q;
  wire [31:0] sync_nxt  = {sync_base[30:0], data_in};

  always @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      state_q    <= ST_IDLE;
      dly_cnt_q  <= 8'h00;
      bit_cnt_q  <= 8'h00;
      word_cnt_q <= 4'h0;
      word_sh_q  <= 32'h00000000;
      hold_q     <= 32'h00000000;
      sync_hold_q <= 32'h00000000;
      cont_q     <= 1'b0;
      xfer_go    <= 1'b0;
      word_done  <= 1'b0;
    end else begin
      xfer_go   <= 1'b0;
      word_done <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          cont_q <= 1'b0;
          if (en_q) begin
            state_q <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (!en_q) begin
            state_q <= ST_IDLE;
          end else if (tick_s && start_ev) begin
            state_q    <= go_state;
            dly_cnt_q  <= f_dly;
            bit_cnt_q  <= 8'h00;
            word_cnt_q <= 4'h0;
            xfer_go    <= (go_state != ST_DELAY);
            cont_q     <= (f_start == 4'h8) & f_stop;
          end
        end
        ST_DELAY: begin
          if (!en_q) begin
            state_q <= ST_IDLE;
          end else if (tick_s) begin
            if (dly_cnt_q == 8'h01) begin
              state_q <= fs_mode ? ST_SYNC : ST_DATA;
              xfer_go <= 1'b1;
            end else begin
              dly_cnt_q <= dly_cnt_q - 8'h01;
            end
          end
        end
        ST_SYNC: begin
          if (tick_s) begin
            sync_hold_q <= sync_nxt;
            if (bit_cnt_q == f_slen) begin
              bit_cnt_q <= 8'h00;
              state_q   <= ST_DATA;
            end else begin
              bit_cnt_q <= bit_cnt_q + 8'h01;
            end
          end
        end
        ST_DATA: begin
          if (tick_s) begin
            word_sh_q <= word_nxt;
            if (cont_q && match1) begin
              cont_q <= 1'b0;
            end
            if (bit_cnt_q == {3'h0, f_wlen}) begin
              bit_cnt_q <= 8'h00;
              hold_q    <= word_nxt;
              word_done <= 1'b1;
              if (!en_q) begin
                state_q <= ST_IDLE;
              end else if (word_cnt_q == f_words) begin
                word_cnt_q <= 4'h0;
                if ((f_start == 4'h0) || (cont_q && !match1)) begin
                  state_q   <= (f_dly != 8'h00) ? ST_DELAY : ST_DATA;
                  dly_cnt_q <= f_dly;
                  xfer_go   <= (f_dly == 8'h00);
                end else begin
                  state_q <= ST_WAIT;
                end
              end else begin
                word_cnt_q <= word_cnt_q + 4'h1;
              end
            end else begin
              bit_cnt_q <= bit_cnt_q + 8'h01;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Enable, start pending and status flags
  // --------------------------------------------------------------------
  // A flag set in the same cycle as its clearing read stays set.
  always @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      en_q        <= 1'b0;
      tx_pend_q   <= 1'b0;
      ready_q     <= 1'b0;
      ovr_q       <= 1'b0;
      sync_seen_q <= 1'b0;
    end else begin
      if (wr_ctrl && WB_SEL_I[0] && WB_DAT_I[`SSR_CTRL_DIS]) begin
        en_q <= 1'b0;
      end else if (wr_ctrl && WB_SEL_I[0] && WB_DAT_I[`SSR_CTRL_EN]) begin
        en_q <= 1'b1;
      end
      if (TX_START_I) begin
        tx_pend_q <= 1'b1;
      end else if (state_q != ST_WAIT) begin
        tx_pend_q <= 1'b0;
      end
      if (word_done) begin
        ready_q <= 1'b1;
      end else if (rd_hold) begin
        ready_q <= 1'b0;
      end
      if (word_done && ready_q && !rd_hold) begin
        ovr_q <= 1'b1;
      end else if (rd_stat) begin
        ovr_q <= 1'b0;
      end
      if (tick_s && (f_edge ? fs_fall : fs_rise)) begin
        sync_seen_q <= 1'b1;
      end else if (rd_stat) begin
        sync_seen_q <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Frame sync generation
  // --------------------------------------------------------------------
  reg  [8:0]  per_cnt_q;
  reg  [7:0]  fs_cnt_q;
  reg         pulse_q;
  reg         tog_q;
  reg         go_pend_q;
  reg         fs_lvl;

  wire        per_hit = (f_per != 8'h00) & (per_cnt_q == {f_per, 1'b1});
  wire        trig    = tick_l & (go_pend_q | per_hit);

  always @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      per_cnt_q <= 9'h000;
      fs_cnt_q  <= 8'h00;
      pulse_q   <= 1'b0;
      tog_q     <= 1'b0;
      go_pend_q <= 1'b0;
    end else begin
      if (xfer_go) begin
        go_pend_q <= 1'b1;
      end else if (tick_l) begin
        go_pend_q <= 1'b0;
      end
      if (tick_l) begin
        if (f_per == 8'h00 || per_hit) begin
          per_cnt_q <= 9'h000;
        end else begin
          per_cnt_q <= per_cnt_q + 9'h001;
        end
        if (trig) begin
          pulse_q  <= 1'b1;
          fs_cnt_q <= f_slen;
        end else if (pulse_q && fs_cnt_q == 8'h00) begin
          pulse_q <= 1'b0;
        end else if (pulse_q) begin
          fs_cnt_q <= fs_cnt_q - 8'h01;
        end
        if (go_pend_q) begin
          tog_q <= ~tog_q;
        end
      end
    end
  end

  always @* begin
    fs_lvl = 1'b0;
    case (f_shape)
      3'h1: fs_lvl = ~pulse_q;
      3'h2: fs_lvl = pulse_q;
      3'h3: fs_lvl = ~busy;
      3'h4: fs_lvl = busy;
      3'h5: fs_lvl = tog_q;
      default: fs_lvl = 1'b0;
    endcase
  end

  always @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      fs_out_q     <= 1'b0;
      RX_FS_O      <= 1'b0;
      RX_FS_OE_N_O <= 1'b1;
    end else begin
      fs_out_q     <= fs_lvl;
      RX_FS_O      <= fs_lvl;
      RX_FS_OE_N_O <= ~fs_drive;
    end
  end

endmodule

/* File: tb/ssr_codec_model.sv */
`timescale 1ns/1ns
module ssr_codec_model (
  input  wire       go_i,
  input  wire [8:0] bits_i,
  output reg        sclk_o,
  output reg        fs_o,
  output reg        sd_o
);
  integer k;
  initial begin
    sclk_o = 1'b0;
    fs_o = 1'b0;
    sd_o = 1'b0;
  end
  // ----
  // Burst: idle bit, sync edge, sync bit, eight data bits msb first
  // ----
  always @(posedge go_i) begin
    // Start off the clock edge so the pins never move as they are sampled.
    #10;
    for (k = 0; k < 11; k = k + 1) begin
      #120 sclk_o = 1'b1;
      fs_o = (k == 1);
      sd_o = (k < 2) ? ~sd_o : bits_i[10 - k];
      #120 sclk_o = 1'b0;
    end
    // The clock stops between frames, so data shows a changed level.
    #120 sd_o = ~sd_o;
  end
endmodule

/* File: tb/ssr_rx_clock_frame_asserts.sv */
`timescale 1ns/1ns
module ssr_rx_clock_frame_asserts (
  input wire        MCLK_I,
  input wire        SYS_RST_I,
  input wire        WB_CYC_I,
  input wire        WB_STB_I,
  input wire        WB_WE_I,
  input wire [7:0]  WB_ADR_I,
  input wire [3:0]  WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  input wire [31:0] WB_DAT_O,
  input wire        WB_ACK_O,
  input wire        RX_FS_OE_N_O,
  input wire        RX_CLK_OE_N_O
);
  // ----
  // Shadow of the pin mode fields
  // ----
  reg  [2:0] drv_q;
  reg  [2:0] shp_q;
  wire       wr = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O;
  always @(posedge MCLK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      drv_q <= 3'h0;
      shp_q <= 3'h0;
    end else begin
      if (wr && WB_ADR_I == 8'h10 && WB_SEL_I[0])
        drv_q <= WB_DAT_I[4:2];
      if (wr && WB_ADR_I == 8'h14 && WB_SEL_I[2])
        shp_q <= WB_DAT_I[22:20];
    end
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (SYS_RST_I);
  a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held longer than one cycle");
  a_ack_next_cycle: assert property
    ((WB_CYC_I && WB_STB_I && !WB_ACK_O) |=> WB_ACK_O)
    else $error("request not answered in the next cycle");
  a_ack_has_cause: assert property
    ($rose(WB_ACK_O) |-> $past(WB_CYC_I && WB_STB_I))
    else $error("ack without a request");
  a_empty_read_zero: assert property (WB_ACK_O && !WB_WE_I &&
    (WB_ADR_I == 8'h08 || WB_ADR_I == 8'h00) |-> WB_DAT_O == 32'h0)
    else $error("unmapped or control read not zero");
  a_clk_pin_released: assert property
    ((drv_q == 3'h0 && $past(drv_q) == 3'h0) |-> RX_CLK_OE_N_O)
    else $error("clock pin driven while input only");
  a_clk_pin_driven: assert property
    ((drv_q == 3'h1 && $stable(drv_q)) |-> !RX_CLK_OE_N_O)
    else $error("clock pin not driven in continuous mode");
  a_sync_pin_released: assert property
    ((shp_q == 3'h0 && $stable(shp_q)) |-> RX_FS_OE_N_O)
    else $error("sync pin driven while input only");
  a_sync_pin_driven: assert property
    ((shp_q inside {[3'h1:3'h5]} && $stable(shp_q)) |-> !RX_FS_OE_N_O)
    else $error("sync pin not driven in output shape");
endmodule
bind ssr_rx_clock_frame ssr_rx_clock_frame_asserts u_chk (
  .MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
  .WB_ACK_O(WB_ACK_O), .RX_FS_OE_N_O(RX_FS_OE_N_O),
  .RX_CLK_OE_N_O(RX_CLK_OE_N_O)
);

/* File: tb/ssr_rx_clock_frame_bench.sv */
`timescale 1ns/1ns
module ssr_rx_clock_frame_bench;
  reg         MCLK_I, SYS_RST_I, WB_CYC_I, WB_STB_I, WB_WE_I;
  reg  [7:0]  WB_ADR_I;
  reg  [3:0]  WB_SEL_I;
  reg  [31:0] WB_DAT_I;
  reg         c_go, t_go, t_start;
  reg  [8:0]  c_bits;
  wire [31:0] WB_DAT_O;
  wire        WB_ACK_O, RX_FS_O, RX_FS_OE_N_O, RX_CLK_O, RX_CLK_OE_N_O;
  wire        c_clk, c_fs, c_sd, t_clk, t_fs, t_sd;
  integer     fails, tests_run;
  ssr_codec_model m_rx (.go_i(c_go), .bits_i(c_bits), .sclk_o(c_clk),
    .fs_o(c_fs), .sd_o(c_sd));
  ssr_codec_model m_tx (.go_i(t_go), .bits_i(c_bits), .sclk_o(t_clk),
    .fs_o(t_fs), .sd_o(t_sd));
  ssr_rx_clock_frame uut (.MCLK_I(MCLK_I), .SYS_RST_I(SYS_RST_I),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .RX_DATA_I(c_sd),
    .RX_FS_I(RX_FS_OE_N_O ? c_fs : RX_FS_O), .RX_FS_O(RX_FS_O),
    .RX_FS_OE_N_O(RX_FS_OE_N_O), .RX_CLK_O(RX_CLK_O),
    .RX_CLK_I(RX_CLK_OE_N_O ? c_clk : RX_CLK_O),
    .RX_CLK_OE_N_O(RX_CLK_OE_N_O), .TX_DATA_I(t_sd), .TX_FS_I(t_fs),
    .TX_CLK_I(t_clk), .TX_START_I(t_start));
  always #20 MCLK_I = ~MCLK_I;
  task conclude;
    begin
      if (fails == 0 && tests_run > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Classic cycle: hold until ack is sampled, then one idle cycle.
  task wb(input w, input [7:0] a, input [31:0] d, output [31:0] r);
    begin
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I <= w;
      WB_ADR_I <= a;
      WB_DAT_I <= d;
      do @(posedge MCLK_I); while (WB_ACK_O !== 1'b1);
      r = WB_DAT_O;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
      @(posedge MCLK_I);
    end
  endtask
  task scn_regs;
    reg [31:0] r;
    begin
      wb(0, 8'h10, 0, r); chk(r, 32'h0);
      wb(0, 8'h14, 0, r); chk(r, 32'h0);
      WB_SEL_I <= 4'h1;
      wb(1, 8'h14, 32'hFFFFFFFF, r);
      WB_SEL_I <= 4'hF;
      wb(0, 8'h14, 0, r); chk(r, 32'h000000BF);
      // Bits 13 to 15 are outside the writable mask and read back as zero.
      wb(1, 8'h10, 32'hFFFFF8AA, r);
      wb(0, 8'h10, 0, r); chk(r, 32'hFFFF18AA);
      wb(0, 8'h08, 0, r); chk(r, 32'h0);
    end
  endtask
  task frame(input [31:0] rf, input [8:0] b, input [31:0] exp);
    reg [31:0] r;
    begin
      wb(1, 8'h14, rf, r);
      c_bits <= b;
      if (rf[5]) t_go <= 1'b1;
      else c_go <= 1'b1;
      // The burst lasts about 70 cycles; the word lands two cycles later.
      repeat (80) @(posedge MCLK_I);
      c_go <= 1'b0;
      t_go <= 1'b0;
      wb(0, 8'h40, 0, r); chk(r[2:0] & 3'h5, 3'h5);
      wb(0, 8'h20, 0, r); chk(r, exp);
      wb(0, 8'h30, 0, r); chk(r, {31'h0, b[8]});
    end
  endtask
  task scn_frames;
    reg [31:0] r;
    begin
      wb(1, 8'h10, 32'h00000502, r);
      wb(1, 8'h00, 32'h1, r);
      frame(32'h87, 9'h1C6, 32'hC6);
      frame(32'h07, 9'h0C6, 32'h63);
      frame(32'hA7, 9'h135, 32'h35);
    end
  endtask
  // A burst without the transmitter start must land no word.
  task scn_tx_start;
    reg [31:0] r;
    integer i;
    begin
      wb(1, 8'h10, 32'h00000102, r);
      wb(1, 8'h14, 32'h00000087, r);
      for (i = 0; i < 2; i = i + 1) begin
        t_start <= i[0];
        @(posedge MCLK_I);
        t_start <= 1'b0;
        c_go <= 1'b1;
        repeat (80) @(posedge MCLK_I);
        c_go <= 1'b0;
        wb(0, 8'h40, 0, r); chk(r[0], i[0]);
        wb(0, 8'h20, 0, r);
      end
    end
  endtask
  task scn_sync_len;
    reg [31:0] r;
    integer i, n;
    begin
      wb(1, 8'h00, 32'h2, r);
      wb(1, 8'h10, 32'h00000004, r);
      wb(1, 8'h04, 32'h2, r);
      wb(1, 8'h14, 32'h1022001F, r);
      wb(1, 8'h00, 32'h1, r);
      n = 0;
      for (i = 0; i < 400 && RX_FS_O !== 1'b1; i = i + 1)
        @(posedge MCLK_I);
      for (i = 0; i < 200 && RX_FS_O === 1'b1; i = i + 1) begin
        n = n + 1;
        @(posedge MCLK_I);
      end
      chk(n, (16 * 1 + 2 + 1) * 4);
    end
  endtask
  initial begin
    MCLK_I = 0; SYS_RST_I = 1; WB_CYC_I = 0; WB_STB_I = 0; WB_WE_I = 0;
    WB_ADR_I = 0; WB_SEL_I = 4'hF; WB_DAT_I = 0;
    c_go = 0; t_go = 0; t_start = 0; c_bits = 0; fails = 0; tests_run = 0;
    repeat (16) @(posedge MCLK_I);
    SYS_RST_I <= 1'b0;
    @(posedge MCLK_I);
    scn_regs;
    scn_frames;
    scn_tx_start;
    scn_sync_len;
    conclude;
  end
  initial begin
    #2000000;
    fails = fails + 1;
    conclude;
  end
endmodule
